// >>> rtl/ssb_defs.vh
/*
 * shared constants of the serial ack/stop buffer block.
 * assumes inclusion by bare name from rtl files.
 */
`ifndef SSB_DEFS_VH
`define SSB_DEFS_VH

// ==========================================================
// widths and reset values
`define SSB_BYTE_W 8
`define SSB_BITCNT_W 4
`define SSB_BYTE_BITS 4'h8
`define SSB_BYTE_RST 8'h00
`define SSB_STAT_RST 8'h00
`define SSB_RELOAD_RST 8'h00

// ==========================================================
// status register field positions
`define SSB_STAT_RO_W 6
`define SSB_STAT_RW_MSB 7
`define SSB_STAT_RW_LSB 6
`define SSB_STAT_STOP_BIT 4
`define SSB_STAT_FULL_BIT 0

// ==========================================================
// sequencer states
`define SSB_ST_IDLE 3'h0
`define SSB_ST_ACK_LOW 3'h1
`define SSB_ST_ACK_HIGH 3'h2
`define SSB_ST_STP_SDA 3'h3
`define SSB_ST_STP_SCL 3'h4
`define SSB_ST_STP_REL 3'h5
`define SSB_ST_STP_DET 3'h6

`endif

// >>> rtl/ssb_rate_gen.v
/*
 * baud rate generator: reloads from the reload value and counts
 * down to zero, pulsing tick_o at each rollover.
 * assumes reload value from a register on the same clock.
 */
`timescale 1ns/1ns
`include "ssb_defs.vh"

module ssb_rate_gen
#(
   parameter W = `SSB_BYTE_W
)
(
   input wire clk_sys_i,
   input wire resetn_i,
   input wire run_i,
   input wire reload_i,
   input wire [W-1:0] reload_val_i,
   output reg tick_o
);

   reg [W-1:0] cnt_r;

   // ==========================================================
   // down counter, held at the reload value when not running
   always @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         cnt_r <= {W{1'b0}};
         tick_o <= 1'b0;
      end
      else if (!run_i || reload_i)
      begin
         cnt_r <= reload_val_i;
         tick_o <= 1'b0;
      end
      else if (cnt_r == {W{1'b0}})
      begin
         cnt_r <= reload_val_i; // rollover
         tick_o <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
         tick_o <= 1'b0;
      end
   end

endmodule

// >>> rtl/ssb_skid_buf.v
/*
 * two-entry buffer with valid and ready on both sides.
 * assumes source and sink on the same clock.
 */
`timescale 1ns/1ns
`include "ssb_defs.vh"

module ssb_skid_buf
#(
   parameter W = `SSB_BYTE_W
)
(
   input wire clk_sys_i,
   input wire resetn_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [W-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [W-1:0] out_data_o
);

   reg [W-1:0] mem_r [0:1];
   reg wr_ptr_r;
   reg rd_ptr_r;
   reg [1:0] count_r;
   wire push;
   wire pop;

   assign in_ready_o = (count_r != 2'h2);
   assign out_valid_o = (count_r != 2'h0);
   assign out_data_o = mem_r[rd_ptr_r];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // ==========================================================
   // storage and pointers
   always @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         mem_r[0] <= {W{1'b0}};
         mem_r[1] <= {W{1'b0}};
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            mem_r[wr_ptr_r] <= in_data_i;
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop)
            rd_ptr_r <= ~rd_ptr_r;
         if (push && !pop)
            count_r <= count_r + 2'h1;
         else if (pop && !push)
            count_r <= count_r - 2'h1;
      end
   end

endmodule

// >>> rtl/ssb_port.v
/*
 * serial port core: spi receive path with double buffering, status
 * and reload registers, and the i2c acknowledge and stop sequences.
 * assumes pins on scl/sda/sdi arrive asynchronously, software
 * strobes come from logic on clk_sys_i.
 */
// Notes on behaviour
// R1: a full received spi byte moves into the transfer buffer and raises the event flag.
// R2: a software buffer write loads both the buffer and the shift register.
// R3: low six status bits are read-only, top two are read/write.
// R4: the rate generator reloads from the software reload value register.
// R5: setting ack enable drives scl low and puts ack data on sda.
// R6: software picks ack data before the ack sequence (0 ack, 1 nack).
// R7: after one period scl is released, once seen high one more period then scl low.
// R8: the ack sequence ends by clearing its enable and going idle; the generator then runs only while rate_run_i is set.
// R9: a buffer write during the ack sequence is dropped and sets write collision.
// R10: after the ninth falling clock the master holds scl low; the code does not count clocks and holds scl low only after an ack sequence.
// R11: setting stop enable drives sda low, once seen low the generator reloads and counts.
// R12: on timeout scl is released, one period later sda is released.
// R13: sda seen high while scl high sets the stop-detected flag.
// R14: one period after stop detect, stop enable clears and the event flag sets.
// R15: a buffer write during the stop sequence is dropped and sets write collision.
// R16: reset clears both enables and collision, idles with lines released.
// R17: software starts one sequence at a time, only from idle.
`timescale 1ns/1ns
`include "ssb_defs.vh"

module ssb_port
#(
   parameter W = `SSB_BYTE_W
)
(
   input wire clk_sys_i,
   input wire resetn_i,
   // software side
   input wire buf_wr_i,
   input wire [W-1:0] buf_wdata_i,
   input wire stat_wr_i,
   input wire [W-1:0] stat_wdata_i,
   input wire reload_wr_i,
   input wire [W-1:0] reload_wdata_i,
   input wire ack_start_i,
   input wire ack_data_value_i,
   input wire stop_start_i,
   input wire flag_clr_i,
   input wire write_collision_flag_clr_i,
   input wire rate_run_i,
   // spi side
   input wire spi_sck_i,
   input wire spi_sdi_i,
   output reg spi_sdo_o,
   // received bytes out through the buffer
   output reg rx_valid_o,
   input wire rx_ready_i,
   output reg [W-1:0] rx_data_o,
   // i2c pins, open drain
   input wire scl_i,
   output reg scl_o,
   output reg scl_oe_o,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe_o,
   // status
   output reg [W-1:0] transfer_buffer_o,
   output reg [W-1:0] port_status_reg_o,
   output reg [W-1:0] reload_value_reg_o,
   output reg ack_sequence_enable_o,
   output reg stop_sequence_enable_o,
   output reg write_collision_flag_o,
   output reg port_event_flag_o
);

   reg [1:0] scl_s_r;
   reg [1:0] sda_s_r;
   reg [1:0] sck_s_r;
   reg [1:0] sdi_s_r;
   reg sck_d_r;
   reg [W-1:0] serial_shift_reg_r;
   reg [`SSB_BITCNT_W-1:0] bit_cnt_r;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   wire rg_reload;
   reg ack_done_r;
   reg stop_done_r;
   reg stop_seen_r;
   wire scl_s;
   wire sda_s;
   wire sck_rise;
   wire sck_fall;
   wire seq_busy;
   wire rg_run;
   wire tick;
   wire byte_done;
   wire buf_in_ready;
   wire buf_out_valid;
   wire [W-1:0] buf_out_data;

   // ==========================================================
   // pin synchronisers
   always @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         scl_s_r <= 2'h3;
         sda_s_r <= 2'h3;
         sck_s_r <= 2'h0;
         sdi_s_r <= 2'h0;
         sck_d_r <= 1'b0;
      end
      else
      begin
         scl_s_r <= {scl_s_r[0], scl_i};
         sda_s_r <= {sda_s_r[0], sda_i};
         sck_s_r <= {sck_s_r[0], spi_sck_i};
         sdi_s_r <= {sdi_s_r[0], spi_sdi_i};
         sck_d_r <= sck_s_r[1];
      end
   end

   assign scl_s = scl_s_r[1];
   assign sda_s = sda_s_r[1];
   assign sck_rise = sck_s_r[1] && !sck_d_r;
   assign sck_fall = !sck_s_r[1] && sck_d_r;
   assign seq_busy = ack_sequence_enable_o || stop_sequence_enable_o;
   assign byte_done = sck_rise &&
      (bit_cnt_r == `SSB_BYTE_BITS - 4'h1);

   // ==========================================================
   // spi shift register: sample on rise, shift out on fall
   always @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         serial_shift_reg_r <= `SSB_BYTE_RST;
         bit_cnt_r <= {`SSB_BITCNT_W{1'b0}};
         spi_sdo_o <= 1'b0;
      end
      else if (buf_wr_i && !seq_busy)
      begin
         serial_shift_reg_r <= buf_wdata_i; // R2
         bit_cnt_r <= {`SSB_BITCNT_W{1'b0}};
         spi_sdo_o <= buf_wdata_i[W-1];
      end
      else
      begin
         if (sck_rise && buf_in_ready)
         begin
            serial_shift_reg_r <= {serial_shift_reg_r[W-2:0],
               sdi_s_r[1]};
            if (byte_done)
               bit_cnt_r <= {`SSB_BITCNT_W{1'b0}};
            else
               bit_cnt_r <= bit_cnt_r + 4'h1;
         end
         if (sck_fall)
            spi_sdo_o <= serial_shift_reg_r[W-1];
      end
   end

   // ==========================================================
   // receive buffer between shifter and reader
   ssb_skid_buf #(.W(W)) u_buf
   (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .in_valid_i(byte_done),
      .in_ready_o(buf_in_ready),
      .in_data_i({serial_shift_reg_r[W-2:0], sdi_s_r[1]}),
      .out_valid_o(buf_out_valid),
      .out_ready_i(rx_ready_i && !rx_valid_o),
      .out_data_o(buf_out_data)
   );

   // ==========================================================
   // output stage of the receive stream
   always @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rx_valid_o <= 1'b0;
         rx_data_o <= `SSB_BYTE_RST;
      end
      else if (rx_valid_o && rx_ready_i)
         rx_valid_o <= 1'b0;
      else if (!rx_valid_o && buf_out_valid && rx_ready_i)
      begin
         rx_valid_o <= 1'b1;
         rx_data_o <= buf_out_data;
      end
   end

   // ==========================================================
   // transfer buffer, status, reload, collision
   always @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         transfer_buffer_o <= `SSB_BYTE_RST;
         port_status_reg_o <= `SSB_STAT_RST;
         reload_value_reg_o <= `SSB_RELOAD_RST;
         write_collision_flag_o <= 1'b0; // R16
      end
      else
      begin
         if (buf_wr_i && seq_busy)
            write_collision_flag_o <= 1'b1; // R9 R15
         else if (write_collision_flag_clr_i)
            write_collision_flag_o <= 1'b0;
         if (buf_wr_i && !seq_busy)
            transfer_buffer_o <= buf_wdata_i; // R2
         else if (byte_done && buf_in_ready)
            transfer_buffer_o <= {serial_shift_reg_r[W-2:0],
               sdi_s_r[1]}; // R1
         if (stat_wr_i)
            port_status_reg_o[`SSB_STAT_RW_MSB:`SSB_STAT_RW_LSB] <=
               stat_wdata_i[`SSB_STAT_RW_MSB:`SSB_STAT_RW_LSB]; // R3
         if (stop_seen_r)
            port_status_reg_o[`SSB_STAT_STOP_BIT] <= 1'b1; // R13
         else if (ack_start_i || stop_start_i)
            port_status_reg_o[`SSB_STAT_STOP_BIT] <= 1'b0;
         if (byte_done && buf_in_ready)
            port_status_reg_o[`SSB_STAT_FULL_BIT] <= 1'b1;
         else if (rx_valid_o && rx_ready_i && !buf_out_valid)
            port_status_reg_o[`SSB_STAT_FULL_BIT] <= 1'b0;
         if (reload_wr_i)
            reload_value_reg_o <= reload_wdata_i; // R4
      end
   end

   // ==========================================================
   // rate generator, runs during sequences or spi master use
   assign rg_run = (state_r != `SSB_ST_IDLE) || rate_run_i;

   // ==========================================================
   // generator reload: at sequence start, while sda is not yet
   // seen low, while scl is held low by a slave, and while the
   // stop condition is awaited, so each timed phase is one period
   assign rg_reload =
      (state_r == `SSB_ST_IDLE && state_nxt != `SSB_ST_IDLE) ||
      (state_r == `SSB_ST_STP_SDA && sda_s) || // R11
      ((state_r == `SSB_ST_ACK_HIGH || state_r == `SSB_ST_STP_SCL) &&
      !scl_s) || // R7 R12
      (state_r == `SSB_ST_STP_REL); // R14

   ssb_rate_gen #(.W(W)) u_rg
   (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .run_i(rg_run),
      .reload_i(rg_reload),
      .reload_val_i(reload_value_reg_o), // R4
      .tick_o(tick)
   );

   // ==========================================================
   // ack and stop sequencer, next state
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         `SSB_ST_IDLE:
            if (ack_start_i)
               state_nxt = `SSB_ST_ACK_LOW; // R5
            else if (stop_start_i)
               state_nxt = `SSB_ST_STP_SDA; // R11
         `SSB_ST_ACK_LOW:
            if (tick)
               state_nxt = `SSB_ST_ACK_HIGH; // R7
         `SSB_ST_ACK_HIGH:
            if (tick && scl_s)
               state_nxt = `SSB_ST_IDLE; // R7 R8
         `SSB_ST_STP_SDA:
            if (tick && !sda_s)
               state_nxt = `SSB_ST_STP_SCL; // R11
         `SSB_ST_STP_SCL:
            if (tick && scl_s)
               state_nxt = `SSB_ST_STP_REL; // R12
         `SSB_ST_STP_REL:
            if (sda_s && scl_s)
               state_nxt = `SSB_ST_STP_DET; // R13
         `SSB_ST_STP_DET:
            if (tick)
               state_nxt = `SSB_ST_IDLE; // R14
         default:
            state_nxt = `SSB_ST_IDLE;
      endcase
   end

   // ==========================================================
   // sequencer registers, enables, pins
   always @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state_r <= `SSB_ST_IDLE;
         ack_sequence_enable_o <= 1'b0; // R16
         stop_sequence_enable_o <= 1'b0; // R16
         port_event_flag_o <= 1'b0;
         stop_seen_r <= 1'b0;
         scl_o <= 1'b0;
         scl_oe_o <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         stop_seen_r <= (state_r == `SSB_ST_STP_REL) &&
            (state_nxt == `SSB_ST_STP_DET);
         if (ack_start_i && state_r == `SSB_ST_IDLE)
            ack_sequence_enable_o <= 1'b1;
         else if (state_r == `SSB_ST_ACK_HIGH &&
            state_nxt == `SSB_ST_IDLE)
            ack_sequence_enable_o <= 1'b0; // R8
         if (stop_start_i && !ack_start_i && state_r == `SSB_ST_IDLE)
            stop_sequence_enable_o <= 1'b1;
         else if (state_r == `SSB_ST_STP_DET && tick)
            stop_sequence_enable_o <= 1'b0; // R14
         if (byte_done || (byte_done == 1'b0 &&
            state_r == `SSB_ST_STP_DET && tick))
            port_event_flag_o <= 1'b1; // R1 R14
         else if (flag_clr_i)
            port_event_flag_o <= 1'b0;
         // scl: low in ack low phase, stop sda phase, and held low
         // after an ack sequence until the next ack or stop sequence releases it
         case (state_nxt)
            `SSB_ST_ACK_LOW, `SSB_ST_STP_SDA:
               scl_oe_o <= 1'b1; // R5 R10
            `SSB_ST_IDLE:
               scl_oe_o <= (state_r == `SSB_ST_ACK_HIGH) ? 1'b1 :
                  (state_r == `SSB_ST_STP_DET) ? 1'b0 : scl_oe_o; // R7
            default:
               scl_oe_o <= 1'b0; // R7 R12
         endcase
         case (state_nxt)
            `SSB_ST_ACK_LOW, `SSB_ST_ACK_HIGH:
               sda_oe_o <= !ack_data_value_i; // R5
            `SSB_ST_STP_SDA, `SSB_ST_STP_SCL:
               sda_oe_o <= 1'b1; // R11
            default:
               sda_oe_o <= 1'b0; // R12
         endcase
      end
   end

endmodule

// >>> sim/ssb_port_sva.sv
/*
 * port-level checker for ssb_port.
 * assumes software holds ack data steady around an ack start.
 */
`timescale 1ns/1ns
module ssb_port_sva
#(
   parameter W = 8
)
(
   input wire clk_sys_i,
   input wire resetn_i,
   input wire buf_wr_i,
   input wire [W-1:0] buf_wdata_i,
   input wire stat_wr_i,
   input wire [W-1:0] stat_wdata_i,
   input wire reload_wr_i,
   input wire [W-1:0] reload_wdata_i,
   input wire ack_start_i,
   input wire ack_data_value_i,
   input wire stop_start_i,
   input wire scl_oe_o,
   input wire sda_oe_o,
   input wire [W-1:0] transfer_buffer_o,
   input wire [W-1:0] port_status_reg_o,
   input wire [W-1:0] reload_value_reg_o,
   input wire ack_sequence_enable_o,
   input wire stop_sequence_enable_o,
   input wire write_collision_flag_o,
   input wire port_event_flag_o
);
   localparam int LIM = 600;
   wire idle = !ack_sequence_enable_o && !stop_sequence_enable_o;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   // =========================================
   // sequence steps
   sequence s_ack_over;
      !ack_sequence_enable_o && scl_oe_o;
   endsequence
   sequence s_stop_over;
      !stop_sequence_enable_o && port_event_flag_o;
   endsequence
   a_ack_begin: assert property (ack_start_i && idle |=> ack_sequence_enable_o
      && scl_oe_o && (sda_oe_o == !$past(ack_data_value_i)))
      else $error("ack start wrong");
   a_ack_bound: assert property ($rose(ack_sequence_enable_o) |->
      ##[1:LIM] s_ack_over)
      else $error("ack never ends");
   a_ack_done: assert property ($fell(ack_sequence_enable_o) |->
      scl_oe_o)
      else $error("ack end scl");
   a_write_collision_flag_set: assert property (buf_wr_i && !idle |=> write_collision_flag_o
      && $stable(transfer_buffer_o))
      else $error("collision miss");
   a_buf_load: assert property (buf_wr_i && idle |=>
      transfer_buffer_o == $past(buf_wdata_i))
      else $error("buffer load");
   a_stat_upper: assert property (stat_wr_i |=>
      port_status_reg_o[7:6] == $past(stat_wdata_i[7:6]))
      else $error("status write");
   a_reload_load: assert property (reload_wr_i |=>
      reload_value_reg_o == $past(reload_wdata_i))
      else $error("reload write");
   a_stop_begin: assert property (stop_start_i && idle |=>
      stop_sequence_enable_o && sda_oe_o)
      else $error("stop start");
   a_stop_order: assert property (stop_sequence_enable_o && $fell(sda_oe_o)
      |-> !scl_oe_o)
      else $error("sda before scl");
   a_stop_bound: assert property ($rose(stop_sequence_enable_o) |->
      ##[1:LIM] s_stop_over)
      else $error("stop never ends");
   a_stop_seen: assert property ($fell(stop_sequence_enable_o) |->
      port_status_reg_o[4])
      else $error("stop bit");
endmodule
bind ssb_port ssb_port_sva #(.W(W)) ssb_port_sva_inst (.*);

// >>> sim/ssb_bus_partner.sv
/*
 * bus far side: pull-ups on scl/sda with optional clock stretch,
 * and an spi source sending bytes msb first.
 * assumes open-drain enables high while pulling low.
 */
`timescale 1ns/1ns
module ssb_bus_partner
(
   input wire clk_sys_i,
   input wire scl_oe_i,
   input wire sda_oe_i,
   input wire stretch_i,
   output wire scl_o,
   output wire sda_o,
   output logic spi_sck_o,
   output logic spi_sdi_o
);
   logic [3:0] rel_cnt;
   // counts cycles since scl release, for stretching
   always @(posedge clk_sys_i)
   begin
      if (scl_oe_i)
         rel_cnt <= 4'h0;
      else if (rel_cnt != 4'hf)
         rel_cnt <= rel_cnt + 4'h1;
   end
   assign scl_o = !(scl_oe_i || (stretch_i && rel_cnt < 4'ha));
   assign sda_o = !sda_oe_i; // pull-up
   initial
   begin
      rel_cnt = 4'h0;
      spi_sck_o = 1'b0;
      spi_sdi_o = 1'b0;
   end
   // one byte, clock idles low outside the frame
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         spi_sdi_o = b[i];
         repeat (4) @(posedge clk_sys_i);
         #1 spi_sck_o = 1'b1;
         repeat (4) @(posedge clk_sys_i);
         #1 spi_sck_o = 1'b0;
      end
      spi_sdi_o = ~spi_sdi_o;
   endtask
endmodule

// >>> sim/tb.sv
/*
 * self-checking bench for ssb_port.
 * assumes the partner model and the bound checker.
 */
`timescale 1ns/1ns
module tb;
   logic clk_sys_i = 0, resetn_i = 0;
   logic buf_wr = 0, stat_wr = 0, reload_wr = 0, ack_start = 0;
   logic ack_dv = 0, stop_start = 0, flag_clr = 0, write_collision_flag_clr = 0;
   logic rate_run = 0, rx_ready = 0, stretch = 0;
   logic [7:0] buf_wd = 8'h00, stat_wd = 8'h00, rel_wd = 8'h00, tb_buf, b;
   wire sck, sdi, sdo, rx_valid, scl, sda, scl_o, sda_o, scl_oe, sda_oe;
   wire [7:0] rx_data, tbuf, stat, rel;
   wire ack_en, stop_en, write_collision_flag, flag;
   integer seed = 32'h0000_ae95, err_total = 0, check_count = 0, n;
   logic [7:0] exp_q[$];
   initial forever #2 clk_sys_i = ~clk_sys_i;
   ssb_port ssb_port_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .buf_wr_i(buf_wr), .buf_wdata_i(buf_wd), .stat_wr_i(stat_wr),
      .stat_wdata_i(stat_wd), .reload_wr_i(reload_wr),
      .reload_wdata_i(rel_wd), .ack_start_i(ack_start),
      .ack_data_value_i(ack_dv), .stop_start_i(stop_start),
      .flag_clr_i(flag_clr), .write_collision_flag_clr_i(write_collision_flag_clr), .rate_run_i(rate_run),
      .spi_sck_i(sck), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
      .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_data_o(rx_data),
      .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .transfer_buffer_o(tbuf),
      .port_status_reg_o(stat), .reload_value_reg_o(rel),
      .ack_sequence_enable_o(ack_en), .stop_sequence_enable_o(stop_en),
      .write_collision_flag_o(write_collision_flag), .port_event_flag_o(flag));
   ssb_bus_partner ssb_bus_partner_inst (.clk_sys_i(clk_sys_i),
      .scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .stretch_i(stretch),
      .scl_o(scl), .sda_o(sda), .spi_sck_o(sck), .spi_sdi_o(sdi));
   task automatic step(input int k);
      repeat (k) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("[FAIL] %0t byte %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("[FAIL] %0t bit %b exp %b", $time, g, e);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // collision write during a sequence
   task automatic bad_write();
      buf_wr = 1; buf_wd = ~tb_buf; step(1); buf_wr = 0;
      chk1(write_collision_flag, 1);
      chk8(tbuf, tb_buf);
      write_collision_flag_clr = 1; step(1); write_collision_flag_clr = 0;
   endtask
   // received byte scoreboard
   always @(posedge clk_sys_i)
   begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk1(1'b1, 1'b0);
         else
            chk8(rx_data, exp_q.pop_front());
      end
   end
   initial
   begin
      #40000;
      err_total++;
      give_verdict();
   end
   initial
   begin
      step(8); resetn_i = 1; step(1);
      chk1(ack_en | stop_en | write_collision_flag, 0);
      chk1(scl_oe | sda_oe, 0);
      chk1(scl_o | sda_o, 0);
      $display("reset test done");
      rel_wd = ($random(seed) & 8'h03) + 8'h01; rate_run = 1;
      reload_wr = 1; step(1); reload_wr = 0; chk8(rel, rel_wd);
      stat_wd = $random(seed); stat_wr = 1; step(1); stat_wr = 0;
      chk8(stat, {stat_wd[7:6], 6'h00});
      tb_buf = $random(seed); buf_wd = tb_buf; buf_wr = 1; step(1);
      buf_wr = 0; chk8(tbuf, tb_buf);
      chk1(sdo, tb_buf[7]);
      $display("register test done");
      // three bytes: two into a stalled receiver, then a ragged drain, then one more
      for (int i = 0; i < 3; i++)
      begin
         b = $random(seed); exp_q.push_back(b);
         ssb_bus_partner_inst.send_byte(b);
         step(8);
         if (i == 1)
         begin
            chk1(flag, 1);
            repeat (30) begin rx_ready = $random(seed); step(1); end
            rx_ready = 1;
         end
      end
      step(8); chk1(exp_q.size() == 0, 1);
      tb_buf = b;
      chk8(tbuf, tb_buf);
      flag_clr = 1; step(1); flag_clr = 0;
      $display("receive test done");
      for (int k = 0; k < 2; k++)
      begin
         ack_dv = k; stretch = k; step(1);
         ack_start = 1; step(1); ack_start = 0;
         chk1(ack_en, 1); chk1(scl_oe, 1); chk1(sda_oe, !k);
         bad_write();
         n = 0;
         while (ack_en === 1'b1 && n < 500) begin step(1); n++; end
         chk1(ack_en, 0); chk1(scl_oe, 1);
      end
      $display("ack test done");
      stop_start = 1; step(1); stop_start = 0;
      chk1(stop_en, 1); chk1(sda_oe, 1);
      ack_start = 1; step(1); ack_start = 0; chk1(ack_en, 0);
      bad_write();
      n = 0;
      while (stop_en === 1'b1 && n < 500) begin step(1); n++; end
      chk1(stop_en, 0); chk1(flag, 1); chk1(stat[4], 1);
      chk1(scl_oe | sda_oe, 0);
      $display("stop test done");
      give_verdict();
   end
endmodule
